/* File: rtl/mgp_pwm_engine.sv */
// mgp_pwm_engine: 48-channel grayscale pwm engine with line sequencing
// assumes: pins come from outside the clock domain and are resynchronised;
// grayscale clock, serial clock and latch are far slower than ref_clk
// Functional notes
// - grayscale clock runs freely; 2^N clocks form a segment
// - on-time equals 16-bit value; zero stays off
// - control bit 8 selects enhanced spectrum mode
// - enhanced mode splits period into 128 segments
// - enhanced mode: at most 512 clocks per segment
// - low seven bits add clocks, bit-reversed order
// - each multiple of 128 adds one clock everywhere
// - full value: 512 clocks, 511 in last segment
// - commands decoded by serial edges during latch
// - line reset clears line count, sets address to 15, loads
// - refresh bit picks deferred or immediate copy
// - line reset advances the group pattern
// - timing reset clears counters, forces outputs off
// - line reset enables caterpillar suppression
// - suppression makes open-led status invalid
// - eight lines: 64 sub-periods, each scans all; engine has no line scan, only counts latches in lineCnt_ff
// - display latch loads slot then copies per refresh
// - group write loads addressed first-latch slot
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module mgp_pwm_engine (
    // clock, reset, freeze
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // wishbone classic slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // controller pins
    input  wire logic                         grayClkPin,
    input  wire logic                         serClkPin,
    input  wire logic                         latchPin,
    input  wire logic                         serDataPin,
    // channel sinks and flags
    output logic [mgp_pkg::CHANNELS-1:0]      channelOutput,
    output logic                              caterpillarEn,
    output logic                              openLedReadValid
);
    import mgp_pkg::*;

    logic [PINS-1:0]     pinIn;
    logic [PINS-1:0]     sync1_ff, sync2_ff, sync3_ff;
    logic [PINS-1:0]     filt_ff, filtPrev_ff;
    logic [PINS-1:0]     pinRise, pinFall;
    logic [ECNT_W-1:0]   edgeCnt_ff;
    logic [CHANNELS-1:0] shift_ff;
    logic [3:0]          addr_ff;
    logic [CHANNELS-1:0] latch1_ff [GROUPS];
    logic [CHANNELS-1:0] latch2_ff [GROUPS];
    logic                cmdWrite, cmdLatch, cmdLine, cmdTiming;
    logic                grayTick, grayWrap, immCopy;
    logic [VAL_W-1:0]    grayCnt_ff;
    logic                copyNow_ff, pending_ff, forceOff_ff;
    logic [CNT8_W-1:0]   lineCnt_ff, pattern_ff;
    logic [SEGCNT_W-1:0] segCnt_ff;
    logic                catEn_ff;
    logic                spectrumMode_ff, refreshBit_ff;
    logic [SEGN_W-1:0]   segBits_ff, nxt_segBits;
    logic [VAL_W-1:0]    segMask;
    logic [VAL_W:0]      segMaskWide;
    logic [CHANNELS-1:0] nxt_chanOut, chanOut_ff;
    logic                wbReq, wbWrite, ack_ff;
    logic [31:0]         rdData, dat_ff;
    logic [SEG_W-1:0]    segIdx, segRank;
    logic [POS_W-1:0]    segPos;

    assign pinIn = {serDataPin, latchPin, serClkPin, grayClkPin};

    // three-stage resynchroniser; a level counts once stages 2 and 3 agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            sync3_ff    <= '0;
            filt_ff     <= '0;
            filtPrev_ff <= '0;
        end else if (ce) begin
            sync1_ff    <= pinIn;
            sync2_ff    <= sync1_ff;
            sync3_ff    <= sync2_ff;
            filtPrev_ff <= filt_ff;
            for (int i = 0; i < PINS; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    filt_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    assign pinRise = filt_ff & ~filtPrev_ff;
    assign pinFall = ~filt_ff & filtPrev_ff;

    // serial edges counted while latch is high, saturating at the top
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edgeCnt_ff <= '0;
        end else if (ce) begin
            if (pinRise[PIN_LATCH]) begin
                edgeCnt_ff <= '0;
            end else if (filt_ff[PIN_LATCH] && pinRise[PIN_SCLK]
                         && edgeCnt_ff != '1) begin
                edgeCnt_ff <= edgeCnt_ff + 1'b1;
            end
        end
    end

    // decode at the latch falling edge; unknown counts are ignored
    assign cmdWrite  = pinFall[PIN_LATCH] && edgeCnt_ff == CMD_GROUP_WRITE;
    assign cmdLatch  = pinFall[PIN_LATCH] && edgeCnt_ff == CMD_DISP_LATCH;
    assign cmdLine   = pinFall[PIN_LATCH] && edgeCnt_ff == CMD_LINE_RESET;
    assign cmdTiming = pinFall[PIN_LATCH] && edgeCnt_ff == CMD_TIMING_RST;
    assign immCopy   = refreshBit_ff && (cmdLatch || cmdLine);

    // serial data enters at the lsb while latch is low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_ff <= '0;
        end else if (ce && pinRise[PIN_SCLK] && !filt_ff[PIN_LATCH]) begin
            shift_ff <= {shift_ff[CHANNELS-2:0], filt_ff[PIN_SDATA]};
        end
    end

    // first latch slot loads and the address that walks them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_ff <= ADDR_TOP;
            for (int g = 0; g < GROUPS; g++) begin
                latch1_ff[g] <= '0;
            end
        end else if (ce) begin
            if (cmdWrite) begin
                latch1_ff[addr_ff] <= shift_ff;
                addr_ff            <= addr_ff - 1'b1;
            end else if (cmdLatch || cmdLine) begin
                latch1_ff[addr_ff] <= shift_ff;
                addr_ff            <= ADDR_TOP;
            end
        end
    end

    assign grayTick = ce && pinRise[PIN_GRAY];
    assign grayWrap = grayTick && grayCnt_ff == '1;

    // second latch: immediate copy one cycle after the command so the
    // just-loaded slot is included, or deferred to the period wrap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            copyNow_ff <= 1'b0;
            pending_ff <= 1'b0;
            for (int g = 0; g < GROUPS; g++) begin
                latch2_ff[g] <= '0;
            end
        end else if (ce) begin
            copyNow_ff <= immCopy;
            if (copyNow_ff || (grayWrap && pending_ff)) begin
                latch2_ff <= latch1_ff;
            end
            if ((cmdLatch || cmdLine) && !refreshBit_ff) begin
                pending_ff <= 1'b1; // set wins over the wrap clear
            end else if (grayWrap || copyNow_ff) begin
                pending_ff <= 1'b0;
            end
        end
    end

    // grayscale counter over the 65536-clock display period; the tick
    // that lifts force-off keeps the count at zero so no on-clock is lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            grayCnt_ff <= '0;
        end else if (ce) begin
            if (cmdTiming || immCopy) begin
                grayCnt_ff <= '0;
            end else if (grayTick && !forceOff_ff) begin
                grayCnt_ff <= grayCnt_ff + 1'b1;
            end
        end
    end

    // forced off until the next grayscale clock; a new force wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            forceOff_ff <= 1'b1;
        end else if (ce) begin
            if (cmdTiming || immCopy) begin
                forceOff_ff <= 1'b1;
            end else if (grayTick) begin
                forceOff_ff <= 1'b0;
            end
        end
    end

    // line count, group pattern and caterpillar suppression
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineCnt_ff <= '0;
            pattern_ff <= '0;
            catEn_ff   <= 1'b0;
        end else if (ce) begin
            if (cmdLine || cmdTiming) begin
                lineCnt_ff <= '0;
            end else if (cmdLatch) begin
                lineCnt_ff <= lineCnt_ff + 1'b1;
            end
            if (cmdLine) begin
                pattern_ff <= pattern_ff + 1'b1;
                catEn_ff   <= 1'b1;
            end
        end
    end

    // segment length 2^N; the count of finished segments is visible
    assign segMaskWide = (17'h1 << segBits_ff) - 17'h1;
    assign segMask     = segMaskWide[VAL_W-1:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            segCnt_ff <= '0;
        end else if (ce) begin
            if (cmdTiming) begin
                segCnt_ff <= '0;
            end else if (grayTick && (grayCnt_ff & segMask) == segMask) begin
                segCnt_ff <= segCnt_ff + 1'b1;
            end
        end
    end

    // enhanced mode: segment index and its bit-reversed rank
    assign segIdx = grayCnt_ff[VAL_W-1:POS_W];
    assign segPos = grayCnt_ff[POS_W-1:0];
    always_comb begin
        segRank = '0;
        for (int b = 0; b < SEG_W; b++) begin
            segRank[b] = segIdx[SEG_W-1-b];
        end
    end

    // per-channel on decision; channel 3g+k uses lane k of group g
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        logic [VAL_W-1:0] val;
        logic [POS_W:0]   limit;
        logic             extra;
        assign val   = latch2_ff[c/COLORS][(c%COLORS)*VAL_W +: VAL_W];
        assign extra = segRank < val[SEG_W-1:0];
        assign limit = {1'b0, val[VAL_W-1:SEG_W]} + {{POS_W{1'b0}}, extra};
        assign nxt_chanOut[c] = !forceOff_ff && (spectrumMode_ff
            ? ({1'b0, segPos} < limit)
            : (grayCnt_ff < val));
    end

    // outputs register the decision, one ref_clk behind the counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chanOut_ff <= '0;
        end else if (ce) begin
            chanOut_ff <= nxt_chanOut;
        end
    end

    assign channelOutput    = chanOut_ff;
    assign caterpillarEn    = catEn_ff;
    assign openLedReadValid = !catEn_ff;

    // wishbone: ack one cycle after the request, write at the ack edge
    assign wbReq   = wb_cyc_i && wb_stb_i;
    assign wbWrite = wbReq && wb_we_i && ack_ff && wb_adr_i == OFS_CTRL;

    always_comb begin
        nxt_segBits = wb_dat_i[CTRL_SEG_LO +: SEGN_W];
        if (nxt_segBits < SEGN_MIN) begin
            nxt_segBits = SEGN_MIN;
        end else if (nxt_segBits > SEGN_MAX) begin
            nxt_segBits = SEGN_MAX;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spectrumMode_ff <= 1'b0;
            refreshBit_ff   <= 1'b0;
            segBits_ff      <= SEGN_RESET;
        end else if (ce && wbWrite) begin
            if (wb_sel_i[0]) begin
                refreshBit_ff <= wb_dat_i[CTRL_REFRESH];
            end
            if (wb_sel_i[1]) begin
                spectrumMode_ff <= wb_dat_i[CTRL_SPECTRUM];
            end
            if (wb_sel_i[2]) begin
                segBits_ff <= nxt_segBits;
            end
        end
    end

    // read mux; unmapped offsets answer with zero
    always_comb begin
        rdData = '0;
        unique case (wb_adr_i)
            OFS_CTRL: begin
                rdData[CTRL_REFRESH]            = refreshBit_ff;
                rdData[CTRL_SPECTRUM]           = spectrumMode_ff;
                rdData[CTRL_SEG_LO +: SEGN_W]   = segBits_ff;
            end
            OFS_STATUS: begin
                rdData[STAT_LINE_LO +: CNT8_W]  = lineCnt_ff;
                rdData[STAT_PAT_LO +: CNT8_W]   = pattern_ff;
                rdData[STAT_CAT]                = catEn_ff;
                rdData[STAT_VALID]              = !catEn_ff;
                rdData[STAT_PENDING]            = pending_ff;
                rdData[STAT_SEG_LO +: SEGCNT_W] = segCnt_ff;
            end
            OFS_COUNT: begin
                rdData[VAL_W-1:0]               = grayCnt_ff;
            end
            default: begin
                rdData = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else if (ce) begin
            ack_ff <= wbReq && !ack_ff;
            if (wbReq && !ack_ff) begin
                dat_ff <= rdData;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // checks on channel 0 and on the command effects
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [VAL_W-1:0] val0;
    logic [POS_W:0]   base0;
    assign val0  = latch2_ff[0][VAL_W-1:0];
    assign base0 = {1'b0, val0[VAL_W-1:SEG_W]};

    sequence lineCmdSeq;
        ce && cmdLine;
    endsequence

    zero_off_a: assert property (ce && val0 == '0 |=> !chanOut_ff[0])
        else $error("zero value channel turned on");
    conv_pulse_a: assert property (ce && !spectrumMode_ff && !forceOff_ff
        && grayCnt_ff < val0 |=> chanOut_ff[0])
        else $error("conventional pulse missing");
    conv_end_a: assert property (ce && !spectrumMode_ff
        && grayCnt_ff >= val0 |=> !chanOut_ff[0])
        else $error("conventional pulse too long");
    seg_base_a: assert property (ce && spectrumMode_ff && !forceOff_ff
        && {1'b0, segPos} < base0 |=> chanOut_ff[0])
        else $error("segment base clocks missing");
    seg_cap_a: assert property (ce && spectrumMode_ff
        && {1'b0, segPos} > base0 |=> !chanOut_ff[0])
        else $error("segment on-time over limit");
    rank_extra_a: assert property (ce && spectrumMode_ff && !forceOff_ff
        && {1'b0, segPos} == base0
        && segRank < val0[SEG_W-1:0] |=> chanOut_ff[0])
        else $error("extra clock not given in rank order");
    line_reset_a: assert property (lineCmdSeq |=> lineCnt_ff == '0
        && addr_ff == ADDR_TOP && catEn_ff)
        else $error("line reset effects missing");
    pattern_step_a: assert property (lineCmdSeq
        |=> pattern_ff == $past(pattern_ff) + 8'h01)
        else $error("group pattern did not advance");
    latch_count_a: assert property (ce && cmdLatch
        |=> lineCnt_ff == $past(lineCnt_ff) + 8'h01)
        else $error("line count did not advance");
    timing_reset_a: assert property (ce && cmdTiming
        |=> grayCnt_ff == '0 && forceOff_ff && lineCnt_ff == '0)
        else $error("timing reset effects missing");
    force_off_a: assert property (ce && forceOff_ff
        |=> chanOut_ff == '0)
        else $error("outputs on while forced off");
    refresh_now_a: assert property (ce && immCopy
        |=> copyNow_ff && forceOff_ff && grayCnt_ff == '0)
        else $error("immediate refresh effects missing");
    group_write_a: assert property (ce && cmdWrite && addr_ff != '0
        |=> addr_ff == $past(addr_ff) - 4'h1)
        else $error("write address did not step");
endmodule : mgp_pwm_engine
`default_nettype wire

/* File: pkg/mgp_pkg.sv */
// mgp_pkg: constants of the multiplexed grayscale pwm engine
// assumes: one 20 MHz clock domain, wishbone register access
package mgp_pkg;
    // geometry
    localparam int CHANNELS  = 48;
    localparam int GROUPS    = 16;
    localparam int COLORS    = 3;
    localparam int VAL_W     = 16;
    localparam int SEG_W     = 7;
    localparam int POS_W     = 9;
    localparam int ECNT_W    = 4;
    localparam logic [3:0] ADDR_TOP = 4'hf;
    // command edge counts while latch is high
    localparam logic [3:0] CMD_GROUP_WRITE = 4'h1;
    localparam logic [3:0] CMD_DISP_LATCH  = 4'h3;
    localparam logic [3:0] CMD_LINE_RESET  = 4'h7;
    localparam logic [3:0] CMD_TIMING_RST  = 4'hd;
    // pin vector positions
    localparam int PIN_GRAY  = 0;
    localparam int PIN_SCLK  = 1;
    localparam int PIN_LATCH = 2;
    localparam int PIN_SDATA = 3;
    localparam int PINS      = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT  = 8'h08;
    // control register fields
    localparam int CTRL_REFRESH = 5;
    localparam int CTRL_SPECTRUM = 8;
    localparam int CTRL_SEG_LO  = 16;
    localparam int SEGN_W       = 5;
    localparam logic [4:0] SEGN_MIN   = 5'h09;
    localparam logic [4:0] SEGN_MAX   = 5'h10;
    localparam logic [4:0] SEGN_RESET = 5'h10;
    // status register fields
    localparam int STAT_LINE_LO  = 0;
    localparam int STAT_PAT_LO   = 8;
    localparam int STAT_CAT      = 16;
    localparam int STAT_VALID    = 17;
    localparam int STAT_PENDING  = 18;
    localparam int STAT_SEG_LO   = 20;
    localparam int CNT8_W        = 8;
    localparam int SEGCNT_W      = 8;
endpackage : mgp_pkg

/* File: tb/mgp_panel_model.sv */
// mgp_panel_model: panel controller that drives the engine's link pins
// assumes: the bench calls its tasks one at a time, right after a ref_clk
// edge; every level is held well beyond the engine's pin filter
`timescale 1ns/1ps
`default_nettype none
module mgp_panel_model (
    // clock
    input  wire logic ref_clk,
    // link pins
    output logic      grayClkPin,
    output logic      serClkPin,
    output logic      latchPin,
    output logic      serDataPin
);
    logic [2:0] rowLine;

    // quiet pins at time zero; serial clock stands low outside frames
    initial begin
        grayClkPin = 1'b0;
        serClkPin  = 1'b0;
        latchPin   = 1'b0;
        serDataPin = 1'b0;
        rowLine    = 3'h0;
    end

    // gray clock never stops; 8 ref_clk per level clears the filter
    always begin
        repeat (8) @(posedge ref_clk);
        grayClkPin <= ~grayClkPin;
    end

    // one serial clock pulse, 5 ref_clk per level
    task automatic sclkPulse();
        serClkPin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        serClkPin <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask : sclkPulse

    // msb first so bit 47 ends at the top of the chain
    task automatic shiftWord(input logic [47:0] d);
        for (int i = 47; i >= 0; i--) begin
            serDataPin <= d[i];
            repeat (2) @(posedge ref_clk);
            sclkPulse();
        end
        serDataPin <= ~d[0];  // stale line shows the inverse, not a held bit
    endtask : shiftWord

    // a command is the count of serial rises inside one latch pulse
    task automatic command(input int n);
        latchPin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        repeat (n) sclkPulse();
        @(posedge grayClkPin);
        repeat (2) @(posedge ref_clk);
        latchPin <= 1'b0;
        if (n == 3 || n == 7) begin
            rowLine <= (n == 7) ? 3'h0 : rowLine + 3'h1;
        end
        repeat (7) @(posedge ref_clk);
    endtask : command

    // fifteen group writes from slot 15 down, then the closing command
    task automatic loadLine(input logic [767:0] img, input int last);
        for (int g = 15; g >= 0; g--) begin
            shiftWord(img[48*g +: 48]);
            command(g == 0 ? last : 1);
        end
    endtask : loadLine
endmodule : mgp_panel_model
`default_nettype wire

/* File: tb/mgp_pwm_engine_tb.sv */
// mgp_pwm_engine_tb: self-checking bench for the grayscale pwm engine
// assumes: the panel model owns the link pins, the bench owns wishbone
`timescale 1ns/1ps
`default_nettype none
module mgp_pwm_engine_tb;
    import mgp_pkg::*;
    typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} mgp_note_t;
    localparam logic [15:0] PICK [6] = '{16'h0000, 16'h0001, 16'h007f,
                                         16'h0080, 16'h0081, 16'hffff};
    logic                ref_clk = 1'b0;
    logic                rst     = 1'b1;
    logic                wbCyc   = 1'b0;
    logic                wbStb   = 1'b0;
    logic                wbWe    = 1'b0;
    logic [7:0]          wbAdr   = 8'h00;
    logic [31:0]         wbDatW  = 32'h0;
    logic [31:0]         wbDatR;
    logic                wbAck;
    logic                grayClk, serClk, latch, serData, catEn, ledValid;
    logic [CHANNELS-1:0] chanOut;
    logic [767:0]        img;
    logic [15:0]         vals [CHANNELS];
    int                  onCnt [CHANNELS];
    logic                msrDone = 1'b0;
    logic                snapOn  = 1'b0;
    mgp_note_t           notes [$];
    int                  mismatches = 0;
    int                  compares = 0;
    int                  seed = 39;

    always #25 ref_clk = ~ref_clk;

    mgp_pwm_engine mgp_pwm_engine_inst (.ref_clk(ref_clk), .rst(rst),
        .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .grayClkPin(grayClk),
        .serClkPin(serClk), .latchPin(latch), .serDataPin(serData),
        .channelOutput(chanOut), .caterpillarEn(catEn),
        .openLedReadValid(ledValid));
    mgp_panel_model mgp_panel_model_inst (.ref_clk(ref_clk),
        .grayClkPin(grayClk), .serClkPin(serClk), .latchPin(latch),
        .serDataPin(serData));

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic note(string nm, logic [31:0] e, logic [31:0] m);
        notes.push_back('{nm, e, m});
    endtask : note

    task automatic check(logic [31:0] seen);
        mgp_note_t n;
        n = '{"missing note", 32'h0, 32'h0};
        compares++;
        if (notes.size() > 0) begin
            n = notes.pop_front();
        end else begin
            mismatches++;
        end
        if ((seen & n.msk) !== (n.exp & n.msk)) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n.nm, n.exp & n.msk,
                     seen & n.msk);
        end
    endtask : check

    // watcher: each read answer or finished window takes the oldest note
    always @(posedge ref_clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) check(wbDatR);
        if (snapOn) check({29'h0, |chanOut, catEn, ledValid});
        if (msrDone) for (int c = 0; c < CHANNELS; c++) check(32'(onCnt[c]));
    end

    // one classic cycle; held until ack is seen, then released a cycle
    task automatic wbXfer(logic we, logic [7:0] adr, logic [31:0] d);
        int n;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbDatW <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            finish_test();
        end else begin
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : wbXfer

    task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
        note(nm, e, m);
        wbXfer(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [31:0] cfg(logic rf, logic es, logic [4:0] n);
        cfg = (32'(n) << CTRL_SEG_LO) | (32'(es) << CTRL_SPECTRUM) |
              (32'(rf) << CTRL_REFRESH);
    endfunction : cfg

    // on-clocks over the first segs segments, bit-reversed extra clocks
    function automatic logic [31:0] esOn(logic [15:0] v, int segs);
        logic [6:0] r;
        esOn = 32'(v[15:7]) * 32'(segs);
        for (int s = 0; s < segs; s++) begin
            for (int i = 0; i < 7; i++) r[i] = s[6-i];
            esOn += 32'(r < v[6:0]);
        end
    endfunction : esOn

    // flags one cycle after the call: {any output on, suppression, valid}
    task automatic snapshot(string nm, logic [2:0] e);
        note(nm, 32'(e), 32'h7);
        snapOn <= 1'b1;
        @(posedge ref_clk);
        snapOn <= 1'b0;
    endtask : snapshot

    // counts on-periods of every channel, sampled at each gray rise
    task automatic measure(int w);
        onCnt = '{default: 0};
        repeat (w) begin
            @(posedge grayClk);
            for (int c = 0; c < CHANNELS; c++) onCnt[c] += int'(chanOut[c] === 1'b1);
        end
        msrDone <= 1'b1;
        @(posedge ref_clk);
        msrDone <= 1'b0;
    endtask : measure

    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        snapshot("reset flags", 3'b001);
        rd("ctrl reset", OFS_CTRL, 32'h00100000, 32'h001f0120);
        rd("unmapped", 8'h0c, 32'h0, 32'hffffffff);
        // segment exponent is clamped into 9..16
        wbXfer(1'b1, OFS_CTRL, cfg(1'b0, 1'b0, 5'h08));
        rd("seg low", OFS_CTRL, cfg(1'b0, 1'b0, 5'h09), 32'h001f0120);
        wbXfer(1'b1, OFS_CTRL, cfg(1'b0, 1'b0, 5'h14));
        rd("seg high", OFS_CTRL, cfg(1'b0, 1'b0, 5'h10), 32'h001f0120);
        // conventional pwm with immediate copy on the display latch
        wbXfer(1'b1, OFS_CTRL, cfg(1'b1, 1'b0, 5'h10));
        mgp_panel_model_inst.command(13);
        rd("line after reset", OFS_STATUS, 32'h00020000, 32'h000300ff);
        for (int c = 0; c < CHANNELS; c++) begin
            vals[c] = 16'($unsigned($random(seed)) % 40);
            img[16*c +: 16] = vals[c];
        end
        mgp_panel_model_inst.loadLine(img, 3);
        for (int c = 0; c < CHANNELS; c++) note("conv on", 32'(vals[c]), '1);
        measure(40);
        rd("line after latch", OFS_STATUS, 32'h00020001, 32'h000300ff);
        // enhanced spectrum, closed by a line reset
        wbXfer(1'b1, OFS_CTRL, cfg(1'b1, 1'b1, 5'h10));
        for (int c = 0; c < CHANNELS; c++) begin
            vals[c] = (c < 6) ? PICK[c] : 16'($random(seed));
            img[16*c +: 16] = vals[c];
        end
        mgp_panel_model_inst.loadLine(img, 7);
        snapshot("line reset flags", 3'b010);
        for (int c = 0; c < CHANNELS; c++) note("es on", esOn(vals[c], 4), '1);
        measure(2049);  // first sample falls in the forced-off period
        rd("line reset status", OFS_STATUS, 32'h00010100, 32'h0003ffff);
        // timing reset in mid display forces every output off
        mgp_panel_model_inst.command(13);
        snapshot("timing reset flags", 3'b010);
        // deferred copy stays pending until the counter wraps
        wbXfer(1'b1, OFS_CTRL, cfg(1'b0, 1'b1, 5'h10));
        mgp_panel_model_inst.command(3);
        rd("deferred", OFS_STATUS, 32'h00050001, 32'h000700ff);
        finish_test();
    end
endmodule : mgp_pwm_engine_tb
`default_nettype wire
